// File: hw/fcu_sched.sv
`timescale 1ns/10ps
`include "fcu_consts.svh"
module fcu_sched (
    input wire logic i_clk_sys, // 20 MHz clock
    input wire logic i_rst, // sync reset, active high
    input wire logic i_rx_tlp_vld, // pulse: tlp received into buffer
    input wire logic [1:0] i_rx_cls, // class of received tlp
    input wire logic [11:0] i_rx_dat_cr, // data credits of received tlp
    input wire logic i_drain_done, // pulse: app finished reading packet
    input wire logic [1:0] i_drain_cls, // class of drained packet
    input wire logic [11:0] i_drain_dat_cr, // data credits of drained packet
    input wire logic i_lim_load, // pulse: partner update received
    input wire logic [1:0] i_lim_cls, // class of partner update
    input wire logic [7:0] i_lim_hdr, // partner header ceiling
    input wire logic [11:0] i_lim_dat, // partner data ceiling
    input wire logic i_tx_req, // app packet wants to go
    input wire logic [1:0] i_tx_cls, // its class
    input wire logic [11:0] i_tx_dat_cr, // its data credits
    input wire logic i_tx_taken, // pulse: packet selected for link
    input wire logic i_tag_alloc, // pulse: read request issued
    input wire logic i_tag_free, // pulse: read completed
    input wire logic i_link_busy, // tlp currently on the wire
    input wire logic i_upd_grant, // arbiter grants update slot
    output logic o_tx_ok, // packet may be sent
    output logic o_tag_ok, // another read tag may be issued
    output logic o_upd_req, // update request pending
    output logic o_upd_hi, // request is high priority
    output logic o_upd_vld, // pulse: update dllp on the link
    output logic [1:0] o_upd_cls, // class of update
    output logic [7:0] o_upd_hdr, // advertised header credits
    output logic [11:0] o_upd_dat, // advertised data credits
    output logic [15:0] o_cpl_hdr_space // completion header slots
);
    // ==========================================
    // per-class counters
    logic [7:0] grant_hdr_r [3];
    logic [11:0] grant_dat_r [3];
    logic [7:0] last_hdr_r [3];
    logic [11:0] last_dat_r [3];
    logic [11:0] rcvd_r [3];
    logic [9:0] timer_r [3];
    logic [7:0] lim_hdr_r [3];
    logic [11:0] lim_dat_r [3];
    logic [7:0] used_hdr_r [3];
    logic [11:0] used_dat_r [3];
    logic [3:0] tags_r;
    logic [2:0] want_w;
    logic [2:0] hi_w;
    logic [1:0] sel_w;
    logic [1:0] cls_r;
    fcu_pkg::fcu_tx_state_t st_r;
    fcu_pkg::fcu_tx_state_t st_nxt;
    localparam logic [9:0] RESEND = 10'(`FCU_RESEND_CYC);

    function automatic logic cls_hit(input logic p, input logic [1:0] c, input int k);
        return p && (c == 2'(k));
    endfunction

    // ==========================================
    // promotion evaluation
    for (genvar k = 0; k < 2; k++) begin : g_eval // completion is unlimited, never updated
        wire logic [11:0] room = last_dat_r[k] - rcvd_r[k];
        wire logic [11:0] gdiff = grant_dat_r[k] - last_dat_r[k];
        wire logic starve = (room < `FCU_MAX_PAYLOAD_CR) && (gdiff != 12'h0_000);
        wire logic stale = timer_r[k] >= RESEND;
        wire logic bulk = gdiff >= (`FCU_DAT_TOTAL >> 2);
        assign want_w[k] = (grant_hdr_r[k] != last_hdr_r[k]) || (gdiff != 12'h0_000) || stale;
        assign hi_w[k] = want_w[k] && (starve || stale || bulk);
    end
    assign want_w[2] = 1'b0;
    assign hi_w[2] = 1'b0;
    assign sel_w = hi_w[0] ? 2'h0 : hi_w[1] ? 2'h1 : want_w[0] ? 2'h0 : 2'h1;
    assign o_upd_req = |want_w;
    assign o_upd_hi = |hi_w;
    assign o_cpl_hdr_space = 16'(`FCU_CPL_BYTES / `FCU_RCB_BYTES);
    assign o_tag_ok = tags_r < `FCU_TAG_MAX;
    // completion ceiling is infinite when advertised as zero
    wire logic tx_cpl_inf = (i_tx_cls == `FCU_CLS_CPL) && (lim_dat_r[i_tx_cls] == 12'h0_000);
    assign o_tx_ok = i_tx_req && (tx_cpl_inf ||
        ((lim_hdr_r[i_tx_cls] - used_hdr_r[i_tx_cls] >= 8'h01) &&
         (lim_dat_r[i_tx_cls] - used_dat_r[i_tx_cls] >= i_tx_dat_cr)));

    // ==========================================
    // update sequencer
    always_comb begin
        st_nxt = st_r;
        case (st_r)
            fcu_pkg::FCU_IDLE: if (o_upd_req && i_upd_grant) st_nxt = fcu_pkg::FCU_WAIT_TLP;
            fcu_pkg::FCU_WAIT_TLP: if (!i_link_busy) st_nxt = fcu_pkg::FCU_SEND;
            fcu_pkg::FCU_SEND: st_nxt = fcu_pkg::FCU_IDLE;
            default: st_nxt = fcu_pkg::FCU_IDLE;
        endcase
    end
    wire logic sending = (st_r == fcu_pkg::FCU_SEND);

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            st_r <= fcu_pkg::FCU_IDLE;
            cls_r <= 2'h0;
            o_upd_vld <= 1'b0;
            o_upd_cls <= 2'h0;
            o_upd_hdr <= 8'h00;
            o_upd_dat <= 12'h0_000;
            tags_r <= 4'h0;
        end else begin
            st_r <= st_nxt;
            if (st_r == fcu_pkg::FCU_IDLE) cls_r <= sel_w;
            o_upd_vld <= sending;
            if (sending) begin
                o_upd_cls <= cls_r;
                o_upd_hdr <= grant_hdr_r[cls_r];
                o_upd_dat <= grant_dat_r[cls_r];
            end
            tags_r <= tags_r + 4'(i_tag_alloc && o_tag_ok) - 4'(i_tag_free && tags_r != 4'h0);
        end
    end

    for (genvar k = 0; k < 3; k++) begin : g_cls
        wire logic sent_k = sending && (cls_r == 2'(k));
        always_ff @(posedge i_clk_sys) begin
            if (i_rst) begin
                grant_hdr_r[k] <= (k == 2) ? 8'h00 : `FCU_HDR_TOTAL;
                grant_dat_r[k] <= (k == 2) ? 12'h0_000 : `FCU_DAT_TOTAL;
                last_hdr_r[k] <= (k == 2) ? 8'h00 : `FCU_HDR_TOTAL;
                last_dat_r[k] <= (k == 2) ? 12'h0_000 : `FCU_DAT_TOTAL;
                rcvd_r[k] <= 12'h0_000;
                timer_r[k] <= 10'h000;
                lim_hdr_r[k] <= 8'h00;
                lim_dat_r[k] <= 12'h0_000;
                used_hdr_r[k] <= 8'h00;
                used_dat_r[k] <= 12'h0_000;
            end else begin
                if (cls_hit(i_drain_done, i_drain_cls, k) && k != 2) begin
                    grant_hdr_r[k] <= grant_hdr_r[k] + 8'h01;
                    grant_dat_r[k] <= grant_dat_r[k] + i_drain_dat_cr;
                end
                if (sent_k) begin
                    last_hdr_r[k] <= grant_hdr_r[k];
                    last_dat_r[k] <= grant_dat_r[k];
                    timer_r[k] <= 10'h000;
                    // a packet landing in the send cycle counts against the new snapshot
                    rcvd_r[k] <= {12{cls_hit(i_rx_tlp_vld, i_rx_cls, k)}} & i_rx_dat_cr;
                end else begin
                    // saturate so a long quiet link cannot wrap and hide staleness
                    if (timer_r[k] != RESEND) timer_r[k] <= timer_r[k] + 10'h001;
                    if (cls_hit(i_rx_tlp_vld, i_rx_cls, k))
                        rcvd_r[k] <= rcvd_r[k] + i_rx_dat_cr;
                end
                if (cls_hit(i_lim_load, i_lim_cls, k)) begin
                    lim_hdr_r[k] <= i_lim_hdr;
                    lim_dat_r[k] <= i_lim_dat;
                end
                if (cls_hit(i_tx_taken, i_tx_cls, k)) begin
                    used_hdr_r[k] <= used_hdr_r[k] + 8'h01;
                    used_dat_r[k] <= used_dat_r[k] + i_tx_dat_cr;
                end
            end
        end
    end

    // ==========================================
    // checks
    wait_busy_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (st_r == fcu_pkg::FCU_WAIT_TLP && i_link_busy) |-> ##2 !o_upd_vld)
        else $error("update sent over a busy packet");
    field_val_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        sending |=> o_upd_dat == $past(grant_dat_r[cls_r]))
        else $error("update field not granted value");
    hi_drop_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        sending |=> timer_r[cls_r] == 10'h000)
        else $error("timer not restarted");
    tag_cap_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        tags_r <= `FCU_TAG_MAX)
        else $error("too many read tags");
    hi_req_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        o_upd_hi |-> o_upd_req)
        else $error("high flag without request");
    stale_hi_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (timer_r[0] == RESEND) |-> o_upd_hi)
        else $error("stale update not promoted");
    cpl_none_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        o_upd_vld |-> o_upd_cls != `FCU_CLS_CPL)
        else $error("completion update sent");
    hold_pkt_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (i_tx_req && i_tx_cls != `FCU_CLS_CPL &&
         lim_dat_r[i_tx_cls] - used_dat_r[i_tx_cls] < i_tx_dat_cr) |-> !o_tx_ok)
        else $error("packet not held");
    grant_hold_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        !i_drain_done |=> $stable(grant_dat_r[0]) && $stable(grant_dat_r[1]))
        else $error("grant moved without a drain");
    cpl_inf_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (i_tx_req && i_tx_cls == `FCU_CLS_CPL && lim_dat_r[2] == 12'h0_000) |-> o_tx_ok)
        else $error("completion held by flow control");
    tag_sat_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (tags_r == `FCU_TAG_MAX && !i_tag_free) |=> tags_r == `FCU_TAG_MAX)
        else $error("tag count passed its limit");
    bulk_hi_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (grant_dat_r[0] - last_dat_r[0] >= (`FCU_DAT_TOTAL >> 2)) |-> o_upd_hi)
        else $error("quarter of buffer not promoted");
    starve_hi_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (last_dat_r[1] - rcvd_r[1] < `FCU_MAX_PAYLOAD_CR && grant_dat_r[1] != last_dat_r[1])
        |-> o_upd_hi)
        else $error("starving partner not promoted");
    send_c: cover property (@(posedge i_clk_sys) o_upd_vld);
    tag_full_c: cover property (@(posedge i_clk_sys) !o_tag_ok);
    both_hi_c: cover property (@(posedge i_clk_sys) hi_w == 3'b011);
    hi_c: cover property (@(posedge i_clk_sys) o_upd_hi && i_upd_grant);
    wait_c: cover property (@(posedge i_clk_sys) st_r == fcu_pkg::FCU_WAIT_TLP && i_link_busy);
endmodule // fcu_sched

// File: hw/fcu_consts.svh
`ifndef FCU_CONSTS_SVH
`define FCU_CONSTS_SVH
// ==========================================
// widths
`define FCU_HDR_W 8
`define FCU_DAT_W 12
`define FCU_NCLS 3
// ==========================================
// class indices
`define FCU_CLS_P 2'h0
`define FCU_CLS_NP 2'h1
`define FCU_CLS_CPL 2'h2
// ==========================================
// receive buffer totals (credits) and payload
`define FCU_HDR_TOTAL 8'h20
`define FCU_DAT_TOTAL 12'h0_0C0
`define FCU_MAX_PAYLOAD_CR 12'h0_010
// completion data space in bytes; headers = bytes / 64
`define FCU_CPL_BYTES 16'h0C00
`define FCU_RCB_BYTES 64
// read tag limit of the eight-lane variant
`define FCU_TAG_MAX 4'h8
// ==========================================
// resend timer
`define FCU_CLK_MHZ 20
`define FCU_RESEND_US 30
`define FCU_RESEND_CYC (`FCU_RESEND_US * `FCU_CLK_MHZ)
`endif

// File: hw/fcu_pkg.sv
package fcu_pkg;
    typedef enum logic [1:0] {
        FCU_IDLE,
        FCU_WAIT_TLP,
        FCU_SEND
    } fcu_tx_state_t;
endpackage

// File: testbench/fcu_far_port.sv
`timescale 1ns/10ps
// ==========================================
// remote port: sends packets, keeps ceilings
module fcu_far_port (
    input wire logic i_clk_sys, // device clock
    input wire logic i_upd_vld, // update dllp seen
    input wire logic [1:0] i_upd_cls, // its class
    input wire logic [11:0] i_upd_dat, // advertised data
    output logic o_rx_vld = 1'b0, // packet strobe
    output logic [1:0] o_rx_cls = 2'h3, // packet class
    output logic [11:0] o_rx_dat = 12'h000 // packet data credits
);
    logic [11:0] ceil_r [3];
    always_ff @(posedge i_clk_sys) begin
        if (i_upd_vld) begin
            ceil_r[i_upd_cls] <= i_upd_dat;
        end
    end
    // released lines show the inverse so a stale value cannot pass
    task automatic send_tlp(input logic [1:0] c, input logic [11:0] d);
        o_rx_vld = 1'b1;
        o_rx_cls = c;
        o_rx_dat = d;
        @(negedge i_clk_sys);
        o_rx_vld = 1'b0;
        o_rx_cls = ~c;
        o_rx_dat = ~d;
        @(negedge i_clk_sys);
    endtask
endmodule // fcu_far_port

// File: testbench/test_fc_update_priority_scheduler.sv
`timescale 1ns/10ps
// ==========================================
// bench: all stimulus at falling edges
module test_fc_update_priority_scheduler;
    logic clk, rst = 1'b1, drn = 1'b0, lim = 1'b0, txr = 1'b0, tkn = 1'b0, ta = 1'b0, tf = 1'b0;
    logic busy = 1'b0, gnt = 1'b0;
    logic [1:0] dc = 2'h0, lc = 2'h0, tc = 2'h0, rc, ucls;
    logic [7:0] lh = 8'h00, uhdr;
    logic [11:0] dd = 12'h000, ld = 12'h000, td = 12'h000, rd, udat;
    logic rv, ok, tok, req, hi, uv;
    logic [15:0] sp;
    logic [21:0] exp_q[$];
    int checks = 0, failures = 0, i;
    int seed = 32'h17de_cfc2;
    fcu_sched fcu_sched_i (.i_clk_sys(clk), .i_rst(rst), .i_rx_tlp_vld(rv), .i_rx_cls(rc),
        .i_rx_dat_cr(rd), .i_drain_done(drn), .i_drain_cls(dc), .i_drain_dat_cr(dd),
        .i_lim_load(lim), .i_lim_cls(lc), .i_lim_hdr(lh), .i_lim_dat(ld), .i_tx_req(txr),
        .i_tx_cls(tc), .i_tx_dat_cr(td), .i_tx_taken(tkn), .i_tag_alloc(ta), .i_tag_free(tf),
        .i_link_busy(busy), .i_upd_grant(gnt), .o_tx_ok(ok), .o_tag_ok(tok), .o_upd_req(req),
        .o_upd_hi(hi), .o_upd_vld(uv), .o_upd_cls(ucls), .o_upd_hdr(uhdr), .o_upd_dat(udat),
        .o_cpl_hdr_space(sp));
    fcu_far_port fcu_far_port_i (.i_clk_sys(clk), .i_upd_vld(uv), .i_upd_cls(ucls),
        .i_upd_dat(udat), .o_rx_vld(rv), .o_rx_cls(rc), .o_rx_dat(rd));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e) begin
            failures++;
            $display("[FAIL] %s exp %h seen %h", n, e, s);
        end
    endtask
    task automatic nx(input int n);
        repeat (n) @(negedge clk);
    endtask
    // two edges so a following pulse never re-drives in the same step
    task automatic pulse(ref logic p);
        p = 1'b1;
        nx(1);
        p = 1'b0;
        nx(1);
    endtask
    task automatic drain(input logic [1:0] c, input logic [11:0] d);
        dc = c;
        dd = d;
        pulse(drn);
    endtask
    task automatic txchk(input logic [11:0] d, input logic e);
        td = d;
        nx(1);
        chk("tx ok", ok, e);
    endtask
    task automatic wait_q;
        for (int k = 0; k < 40 && exp_q.size() > 0; k++) nx(1);
        chk("queue", exp_q.size(), 0);
    endtask
    task close_out;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // outputs launch on the rising edge, so they are read mid-cycle
    always @(negedge clk) begin
        if (uv === 1'b1) begin
            chk("update", {ucls, uhdr, udat}, exp_q.size() ? exp_q.pop_front() : 'x);
        end
    end
    initial begin
        #300_000;
        failures++;
        close_out;
    end
    initial begin
        nx(16);
        rst = 1'b0;
        nx(1);
        chk("cpl space", sp, 16'h0030);
        chk("idle req", req, 1'b0);
        lh = 8'h02;
        ld = 12'h010;
        pulse(lim);
        txr = 1'b1;
        for (i = 0; i < 8; i++) begin
            td = 12'($random(seed)) & 12'h01F;
            txchk(td, td <= 12'h010);
        end
        td = 12'h005;
        pulse(tkn);
        txchk(12'h00B, 1'b1);
        txchk(12'h00C, 1'b0);
        td = 12'h000;
        pulse(tkn);
        txchk(12'h000, 1'b0);
        tc = 2'h1;
        txchk(12'h000, 1'b0);
        lc = 2'h1;
        ld = 12'h004;
        pulse(lim);
        txchk(12'h004, 1'b1);
        txchk(12'h005, 1'b0);
        tc = 2'h2;
        txchk(12'h0FF, 1'b1);
        txr = 1'b0;
        $display("tx limits done");
        drain(2'h0, 12'h02F);
        chk("low pri", {req, hi}, 2'b10);
        drain(2'h0, 12'h001);
        chk("quarter", hi, 1'b1);
        exp_q.push_back({2'h0, 8'h22, 12'h0F0});
        busy = 1'b1;
        gnt = 1'b1;
        nx(6);
        chk("held", exp_q.size(), 1);
        busy = 1'b0;
        wait_q;
        gnt = 1'b0;
        nx(1);
        chk("after send", {req, hi}, 2'b00);
        chk("ceiling", fcu_far_port_i.ceil_r[0], 12'h0F0);
        $display("quarter done");
        drain(2'h1, 12'h001);
        chk("low pri", {req, hi}, 2'b10);
        fcu_far_port_i.send_tlp(2'h1, 12'h0B1);
        chk("starve", hi, 1'b1);
        exp_q.push_back({2'h1, 8'h21, 12'h0C1});
        gnt = 1'b1;
        wait_q;
        gnt = 1'b0;
        $display("starve done");
        nx(560);
        chk("timer early", hi, 1'b0);
        nx(50);
        chk("timer", {req, hi}, 2'b11);
        exp_q.push_back({2'h0, 8'h22, 12'h0F0});
        exp_q.push_back({2'h1, 8'h21, 12'h0C1});
        gnt = 1'b1;
        wait_q;
        gnt = 1'b0;
        $display("timer done");
        drain(2'h2, 12'h008);
        chk("cpl req", req, 1'b0);
        repeat (9) pulse(ta);
        chk("tag full", tok, 1'b0);
        pulse(tf);
        chk("tag free", tok, 1'b1);
        $display("cpl and tags done");
        close_out;
    end
endmodule // test_fc_update_priority_scheduler
